//--- src/ptonp_regs.sv
// Purpose: 10 Mbps option control and next page transmit registers with their effects
// Assumes: Management port strobes are synchronous one-cycle pulses
// Notes: Read data is registered and valid one cycle after the read strobe
`timescale 1ns/100ps
module ptonp_regs #(
  parameter int unsigned POL_THRESH = ptonp_pkg::POL_THRESH_DEF
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  // Management register port
  input wire logic [ptonp_pkg::ADDR_W-1:0] MGMT_ADDR_I,
  input wire logic MGMT_WE_I,
  input wire logic MGMT_RE_I,
  input wire logic [ptonp_pkg::REG_W-1:0] MGMT_WDATA_I,
  output logic [ptonp_pkg::REG_W-1:0] MGMT_RDATA_O,
  output logic MGMT_RVALID_O,
  // Line state
  input wire logic SPEED100_I,
  // Phase references
  input wire logic INT_PHASE_REF_I,
  input wire logic EXTERNAL_PHASE_REFERENCE_I,
  output logic PHASE_REF_O,
  // 10 Mbps mode controls
  output logic LINK_PULSE_TX_EN_O,
  output logic LINK_PULSE_CHECK_EN_O,
  output logic SERIAL_MODE_O,
  output logic SQUELCH_LOW_O,
  output logic HEARTBEAT_EN_O,
  // Receive polarity
  input wire logic PULSE_REV_I,
  input wire logic PULSE_FWD_I,
  input wire logic RX_DATA_I,
  output logic RX_DATA_O,
  output logic POL_INVERT_O,
  output logic AUTOPOL_STATUS_O,
  // Next page exchange with the arbitration logic
  input wire logic BASE_DONE_I,
  input wire logic BASE_TOGGLE_I,
  input wire logic PAGE_DONE_I,
  input wire logic RX_ACK_I,
  input wire logic TX_ACK_I,
  output logic [ptonp_pkg::REG_W-1:0] TX_PAGE_O,
  output logic PAGE_PENDING_O
);

  ptonp_pkg::ptonp_opt_t opt;
  ptonp_pkg::ptonp_page_t page;
  logic speed10;
  logic hit_opt;
  logic hit_np;
  logic first_pending;
  logic phase_ref;
  logic [ptonp_pkg::REG_W-1:0] next_rdata;
  logic [ptonp_pkg::REG_W-1:0] opt_wdata;

  function automatic logic [ptonp_pkg::REG_W-1:0] masked(
    input logic [ptonp_pkg::REG_W-1:0] data,
    input logic [ptonp_pkg::REG_W-1:0] mask
  );
    masked = data & mask;
  endfunction : masked

  assign speed10 = !SPEED100_I;
  assign hit_opt = MGMT_ADDR_I == ptonp_pkg::REG_TENMEG_OPT;
  assign hit_np = MGMT_ADDR_I == ptonp_pkg::REG_NEXT_PAGE;
  assign opt_wdata = masked(MGMT_WDATA_I, ptonp_pkg::OPT_WR_MASK);

  // Option control register
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      opt <= ptonp_pkg::OPT_RESET[ptonp_pkg::OPT_USED_W-1:0];
    end else if (CE_I && MGMT_WE_I && hit_opt) begin
      opt <= opt_wdata[ptonp_pkg::OPT_USED_W-1:0];
    end
  end

  // Writable next page fields; toggle and ack have their own processes
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      page.code <= ptonp_pkg::NP_RESET[ptonp_pkg::NP_CODE_W-1:0];
      page.ack2 <= ptonp_pkg::NP_RESET[ptonp_pkg::NP_ACK2];
      page.msg_page <= ptonp_pkg::NP_RESET[ptonp_pkg::NP_MSG_PAGE];
      page.next_page <= ptonp_pkg::NP_RESET[ptonp_pkg::NP_NEXT_PAGE];
    end else if (CE_I && MGMT_WE_I && hit_np) begin
      page.code <= MGMT_WDATA_I[ptonp_pkg::NP_CODE_W-1:0];
      page.ack2 <= MGMT_WDATA_I[ptonp_pkg::NP_ACK2];
      page.msg_page <= MGMT_WDATA_I[ptonp_pkg::NP_MSG_PAGE];
      page.next_page <= MGMT_WDATA_I[ptonp_pkg::NP_NEXT_PAGE];
    end
  end

  // Toggle ignores software writes
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      page.toggle <= ptonp_pkg::NP_RESET[ptonp_pkg::NP_TOGGLE];
      first_pending <= 1'b1;
    end else if (CE_I) begin
      if (BASE_DONE_I) begin
        page.toggle <= !BASE_TOGGLE_I;
        first_pending <= 1'b0;
      end else if (PAGE_DONE_I && !first_pending) begin
        page.toggle <= !page.toggle;
      end
    end
  end

  // Acknowledge follows the received link code word
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      page.ack <= ptonp_pkg::NP_RESET[ptonp_pkg::NP_ACK];
    end else if (CE_I) begin
      page.ack <= RX_ACK_I;
    end
  end

  // Page pending: a write loads a page, a next page exchange consumes it, a base page exchange does not; a write wins
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PAGE_PENDING_O <= 1'b0;
    end else if (CE_I) begin
      if (MGMT_WE_I && hit_np) begin
        PAGE_PENDING_O <= 1'b1;
      end else if (PAGE_DONE_I) begin
        PAGE_PENDING_O <= 1'b0;
      end
    end
  end

  // Outgoing link code word carries own toggle and ack
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      TX_PAGE_O <= ptonp_pkg::NP_RESET;
    end else if (CE_I) begin
      TX_PAGE_O <= {page.next_page, TX_ACK_I, page.msg_page, page.ack2,
        page.toggle, page.code};
    end
  end

  // Read data mux
  always_comb begin
    next_rdata = ptonp_pkg::READ_ZERO;
    if (hit_opt) begin
      next_rdata = ptonp_pkg::READ_ZERO | {{(ptonp_pkg::REG_W - ptonp_pkg::OPT_USED_W){1'b0}}, opt};
    end else if (hit_np) begin
      next_rdata = page;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      MGMT_RDATA_O <= ptonp_pkg::READ_ZERO;
      MGMT_RVALID_O <= 1'b0;
    end else if (CE_I) begin
      MGMT_RVALID_O <= MGMT_RE_I;
      if (MGMT_RE_I) begin
        MGMT_RDATA_O <= next_rdata;
      end
    end
  end

  // Mode controls; 10 Mbps-only options are gated by the speed
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      LINK_PULSE_TX_EN_O <= 1'b0;
      LINK_PULSE_CHECK_EN_O <= 1'b0;
      SERIAL_MODE_O <= 1'b0;
      SQUELCH_LOW_O <= 1'b0;
      HEARTBEAT_EN_O <= 1'b0;
    end else if (CE_I) begin
      LINK_PULSE_TX_EN_O <= speed10 && !opt.no_link_pulse;
      LINK_PULSE_CHECK_EN_O <= speed10 && !opt.no_link_pulse;
      SERIAL_MODE_O <= speed10 && opt.serial_sel;
      SQUELCH_LOW_O <= speed10 && opt.ext_line;
      HEARTBEAT_EN_O <= speed10 && opt.heartbeat;
    end
  end

  // Phase reference select; registered, so one cycle of latency on the reference
  assign phase_ref = opt.ref_sel ? EXTERNAL_PHASE_REFERENCE_I : INT_PHASE_REF_I;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      PHASE_REF_O <= 1'b0;
    end else if (CE_I) begin
      PHASE_REF_O <= phase_ref;
    end
  end

  ptonp_polarity #(
    .THRESH(POL_THRESH)
  ) u_polarity (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .ce_i(CE_I),
    .speed100_i(SPEED100_I),
    .flag_en_i(opt.autopol_en),
    .pulse_rev_i(PULSE_REV_I),
    .pulse_fwd_i(PULSE_FWD_I),
    .rx_data_i(RX_DATA_I),
    .invert_o(POL_INVERT_O),
    .status_o(AUTOPOL_STATUS_O),
    .rx_data_o(RX_DATA_O)
  );

endmodule : ptonp_regs

//--- inc/ptonp_pkg.sv
// Purpose: Constants and types for the 10 Mbps option and next page register block
// Assumes: 16-bit management registers, 5-bit register number
// Notes: Register numbers are local choices, see hand-over
// Notes on behaviour
// - With the link-pulse-disable bit set, 10 Mbps runs without sending or checking link pulses.
// - The serial select bit selects 10 Mbps serial mode and is ignored at 100 Mbps.
// - The reference select bit switches phase alignment to the external 10 MHz reference.
// - With autopolarity enabled at 10 Mbps, a reversed pair is detected, corrected and flagged.
// - With autopolarity disabled at 10 Mbps, a reversed pair is still corrected.
// - The extended line length bit lowers the squelch levels, at 10 Mbps only.
// - The heartbeat bit enables the signal quality error test, at 10 Mbps only.
// - The next page register holds a writable 11-bit message or unformatted code in its low bits.
// - The toggle bit is read-only and is the inverse of the toggle of the last exchanged page.
// - The first next page toggle is the inverse of bit 11 of the base link code word.
// - The second acknowledge bit is written and sent: 0 cannot comply, 1 complies.
// - The message page bit marks 0 unformatted page, 1 formatted message page.
// - Bit 14 of the next page register reads back the acknowledge of the link code word.
// - The next page bit marks 0 last page, 1 another page follows.
// - The autopolarity status flag reads 1 after a corrected reversal with autopolarity enabled, not meaningful at 100 Mbps.
package ptonp_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned ADDR_W = 5;

  // Register numbers on the management port
  localparam logic [ADDR_W-1:0] REG_NEXT_PAGE = 5'h07;
  localparam logic [ADDR_W-1:0] REG_TENMEG_OPT = 5'h1E;

  // Option control field positions
  localparam int unsigned OPT_NO_LINK_PULSE = 0;
  localparam int unsigned OPT_SERIAL_SEL = 1;
  localparam int unsigned OPT_REF_SEL = 2;
  localparam int unsigned OPT_AUTOPOL_EN = 3;
  localparam int unsigned OPT_EXT_LINE = 4;
  localparam int unsigned OPT_HEARTBEAT = 5;
  localparam int unsigned OPT_USED_W = 6;
  localparam logic [REG_W-1:0] OPT_RESET = 16'h0000;
  localparam logic [REG_W-1:0] OPT_WR_MASK = 16'h003F;

  // Next page field positions
  localparam int unsigned NP_CODE_W = 11;
  localparam int unsigned NP_TOGGLE = 11;
  localparam int unsigned NP_ACK2 = 12;
  localparam int unsigned NP_MSG_PAGE = 13;
  localparam int unsigned NP_ACK = 14;
  localparam int unsigned NP_NEXT_PAGE = 15;
  localparam logic [REG_W-1:0] NP_RESET = 16'h0000;
  localparam logic [REG_W-1:0] NP_WR_MASK = 16'hB7FF;

  localparam logic [REG_W-1:0] READ_ZERO = 16'h0000;

  // Consecutive reversed link pulses before the pair is declared reversed
  localparam int unsigned POL_THRESH_DEF = 3;

  typedef struct packed {
    logic heartbeat;
    logic ext_line;
    logic autopol_en;
    logic ref_sel;
    logic serial_sel;
    logic no_link_pulse;
  } ptonp_opt_t;

  typedef struct packed {
    logic next_page;
    logic ack;
    logic msg_page;
    logic ack2;
    logic toggle;
    logic [NP_CODE_W-1:0] code;
  } ptonp_page_t;

  typedef enum logic [0:0] {
    POL_NORMAL,
    POL_REVERSED
  } ptonp_pol_t;

endpackage : ptonp_pkg

//--- src/ptonp_polarity.sv
// Purpose: Receive pair polarity detection and correction for 10 Mbps
// Assumes: Link pulse polarity indications are one-cycle strobes
// Notes: Correction acts whatever the enable; the enable only gates the status flag
`timescale 1ns/100ps
module ptonp_polarity #(
  parameter int unsigned THRESH = ptonp_pkg::POL_THRESH_DEF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic speed100_i,
  input wire logic flag_en_i,
  input wire logic pulse_rev_i,
  input wire logic pulse_fwd_i,
  input wire logic rx_data_i,
  output logic invert_o,
  output logic status_o,
  output logic rx_data_o
);

  localparam int unsigned CNT_W = $clog2(THRESH + 1);
  localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(THRESH);
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  ptonp_pkg::ptonp_pol_t state;
  logic [CNT_W-1:0] run;
  logic opposing;

  // A pulse that disagrees with the current belief about the pair
  assign opposing = (state == ptonp_pkg::POL_NORMAL) ? pulse_rev_i : pulse_fwd_i;

  // Debounce so a single noisy pulse cannot flip the pair
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      run <= '0;
    end else if (ce_i) begin
      if (speed100_i || (pulse_rev_i == pulse_fwd_i)) begin
        run <= run;
      end else if (!opposing || run == CNT_MAX - CNT_ONE) begin
        // Restart at the flip edge, so flipping back takes a full run too
        run <= '0;
      end else begin
        run <= run + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ptonp_pkg::POL_NORMAL;
    end else if (ce_i) begin
      case (state)
        ptonp_pkg::POL_NORMAL: begin
          if (!speed100_i && opposing && !pulse_fwd_i && run == CNT_MAX - CNT_ONE) begin
            state <= ptonp_pkg::POL_REVERSED;
          end
        end
        ptonp_pkg::POL_REVERSED: begin
          if (!speed100_i && opposing && !pulse_rev_i && run == CNT_MAX - CNT_ONE) begin
            state <= ptonp_pkg::POL_NORMAL;
          end
        end
        default: begin
          state <= ptonp_pkg::POL_NORMAL;
        end
      endcase
    end
  end

  assign invert_o = (state == ptonp_pkg::POL_REVERSED) && !speed100_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_o <= 1'b0;
      rx_data_o <= 1'b0;
    end else if (ce_i) begin
      status_o <= invert_o && flag_en_i;
      rx_data_o <= rx_data_i ^ invert_o;
    end
  end

endmodule : ptonp_polarity

//--- verification/ptonp_checker.sv
// Purpose: Port assertions for the option and next page registers
// Assumes: Edges as in the hand-over timing
// Notes: Bound into every ptonp_regs
`timescale 1ns/100ps
module ptonp_checker (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic MGMT_RE_I,
  input wire logic MGMT_RVALID_O,
  input wire logic SPEED100_I,
  input wire logic SERIAL_MODE_O,
  input wire logic SQUELCH_LOW_O,
  input wire logic HEARTBEAT_EN_O,
  input wire logic LINK_PULSE_TX_EN_O,
  input wire logic LINK_PULSE_CHECK_EN_O,
  input wire logic RX_DATA_I,
  input wire logic RX_DATA_O,
  input wire logic POL_INVERT_O,
  input wire logic AUTOPOL_STATUS_O,
  input wire logic BASE_DONE_I,
  input wire logic BASE_TOGGLE_I,
  input wire logic PAGE_DONE_I,
  input wire logic TX_ACK_I,
  input wire logic [ptonp_pkg::REG_W-1:0] TX_PAGE_O
);
  logic base_seen;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // Toggle only moves once a base page was exchanged
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      base_seen <= 1'b0;
    end else if (CE_I && BASE_DONE_I) begin
      base_seen <= 1'b1;
    end
  end
  sequence s_quiet;
    CE_I && !BASE_DONE_I && !PAGE_DONE_I;
  endsequence
  sequence s_base;
    CE_I && BASE_DONE_I ##1 s_quiet;
  endsequence
  sequence s_page;
    CE_I && PAGE_DONE_I && !BASE_DONE_I && base_seen ##1 s_quiet;
  endsequence
  a_rvalid_pulse: assert property (CE_I |=> MGMT_RVALID_O == $past(MGMT_RE_I))
    else $error("read valid wrong");
  a_fast_gate: assert property (CE_I && SPEED100_I |=> !(SERIAL_MODE_O ||
    SQUELCH_LOW_O || HEARTBEAT_EN_O || LINK_PULSE_TX_EN_O || LINK_PULSE_CHECK_EN_O))
    else $error("10M control active at 100M");
  a_lp_same: assert property (LINK_PULSE_TX_EN_O == LINK_PULSE_CHECK_EN_O)
    else $error("link pulse enables differ");
  a_pol_fast: assert property (SPEED100_I |-> !POL_INVERT_O)
    else $error("inversion at 100M");
  a_rx_fix: assert property (CE_I |=> RX_DATA_O == ($past(RX_DATA_I) ^ $past(POL_INVERT_O)))
    else $error("receive data not corrected");
  a_status_src: assert property (CE_I && !POL_INVERT_O |=> !AUTOPOL_STATUS_O)
    else $error("status without reversal");
  a_tx_ack: assert property ((CE_I && TX_ACK_I) [*3] |-> TX_PAGE_O[14])
    else $error("own ack not sent");
  a_base_toggle: assert property (s_base |=> TX_PAGE_O[11] == !$past(BASE_TOGGLE_I, 2))
    else $error("first toggle wrong");
  a_page_toggle: assert property (s_page |=> TX_PAGE_O[11] != $past(TX_PAGE_O[11]))
    else $error("toggle did not flip");
  c_page: cover property (s_page);
endmodule : ptonp_checker

bind ptonp_regs ptonp_checker u_chk (.CLK_I, .NRST_I, .CE_I, .MGMT_RE_I, .MGMT_RVALID_O,
  .SPEED100_I, .SERIAL_MODE_O, .SQUELCH_LOW_O, .HEARTBEAT_EN_O, .LINK_PULSE_TX_EN_O,
  .LINK_PULSE_CHECK_EN_O, .RX_DATA_I, .RX_DATA_O, .POL_INVERT_O, .AUTOPOL_STATUS_O,
  .BASE_DONE_I, .BASE_TOGGLE_I, .PAGE_DONE_I, .TX_ACK_I, .TX_PAGE_O);

//--- verification/ptonp_link_model.sv
// Purpose: Far side: link pulses and page exchange events
// Assumes: One-cycle strobes, changed at the rising edge
// Notes: Tasks are called from the bench
`timescale 1ns/100ps
module ptonp_link_model (
  input wire logic clk_i,
  output logic pulse_rev_o,
  output logic pulse_fwd_o,
  output logic base_done_o,
  output logic base_toggle_o,
  output logic page_done_o
);
  initial begin
    {pulse_rev_o, pulse_fwd_o, base_done_o, base_toggle_o, page_done_o} = 5'h00;
  end
  task automatic pulses(input logic rev, input int n);
    repeat (n) begin
      @(posedge clk_i);
      pulse_rev_o <= rev;
      pulse_fwd_o <= !rev;
    end
    @(posedge clk_i);
    {pulse_rev_o, pulse_fwd_o} <= 2'h0;
  endtask : pulses
  // Toggle line inverted once released, so a stale level never passes
  task automatic exchange(input logic base, input logic tog);
    @(posedge clk_i);
    base_done_o <= base;
    page_done_o <= !base;
    base_toggle_o <= tog;
    @(posedge clk_i);
    {base_done_o, page_done_o, base_toggle_o} <= {2'h0, !tog};
  endtask : exchange
endmodule : ptonp_link_model

//--- verification/ptonp_regs_tb.sv
// Purpose: Self-checking bench for ptonp_regs
// Assumes: Clock enable high except in its own test
// Notes: Reset values first, then option rows, enable, pages, polarity and a mid-run reset
`timescale 1ns/100ps
module ptonp_regs_tb;
  typedef struct packed {
    logic spd;
    logic [15:0] wd;
    logic [15:0] rb;
    logic [4:0] outs;
  } ptonp_row_t;
  // Outs: link pulses, serial, squelch, heartbeat, phase reference
  ptonp_row_t rows [7] = '{'{1'b0, 16'h0000, 16'h0000, 5'h10}, '{1'b0, 16'hFFFF, 16'h003F, 5'h0F},
    '{1'b0, 16'h0021, 16'h0021, 5'h02}, '{1'b0, 16'h0012, 16'h0012, 5'h1C},
    '{1'b0, 16'h0004, 16'h0004, 5'h11}, '{1'b1, 16'h003F, 16'h003F, 5'h01},
    '{1'b1, 16'h0000, 16'h0000, 5'h00}};
  logic clk, nrst, we, re, rv, spd, ph, lpt, lpc, ser, sq, hb, prev, pfwd, rxd, rxo, inv, st;
  logic bd, bt, pd, rxack, txack, pend, ce;
  logic [4:0] addr;
  logic [15:0] wd, rdata, txp, d;
  int n_fail = 0;
  int comparisons = 0;
  localparam logic [4:0] OPT = ptonp_pkg::REG_TENMEG_OPT;
  localparam logic [4:0] NP = ptonp_pkg::REG_NEXT_PAGE;
  ptonp_regs DUT (.CLK_I(clk), .NRST_I(nrst), .CE_I(ce), .MGMT_ADDR_I(addr),
    .MGMT_WE_I(we), .MGMT_RE_I(re), .MGMT_WDATA_I(wd), .MGMT_RDATA_O(rdata),
    .MGMT_RVALID_O(rv), .SPEED100_I(spd), .INT_PHASE_REF_I(1'b0),
    .EXTERNAL_PHASE_REFERENCE_I(1'b1), .PHASE_REF_O(ph), .LINK_PULSE_TX_EN_O(lpt),
    .LINK_PULSE_CHECK_EN_O(lpc), .SERIAL_MODE_O(ser), .SQUELCH_LOW_O(sq),
    .HEARTBEAT_EN_O(hb), .PULSE_REV_I(prev), .PULSE_FWD_I(pfwd), .RX_DATA_I(rxd),
    .RX_DATA_O(rxo), .POL_INVERT_O(inv), .AUTOPOL_STATUS_O(st), .BASE_DONE_I(bd),
    .BASE_TOGGLE_I(bt), .PAGE_DONE_I(pd), .RX_ACK_I(rxack), .TX_ACK_I(txack),
    .TX_PAGE_O(txp), .PAGE_PENDING_O(pend));
  ptonp_link_model lm (.clk_i(clk), .pulse_rev_o(prev), .pulse_fwd_o(pfwd),
    .base_done_o(bd), .base_toggle_o(bt), .page_done_o(pd));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wd <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    d = rdata;
    check({15'h0, rv}, 16'h0001);
  endtask : rd
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic end_sim;
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  initial begin
    {nrst, we, re, spd, rxd, rxack, txack, addr, wd} = '0;
    ce = 1'b1;
    settle(5);
    check(txp, 16'h0000);
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd(NP);
    check(d, ptonp_pkg::NP_RESET);
    rd(OPT);
    check(d, ptonp_pkg::OPT_RESET);
    wr(5'h00, 16'hFFFF);
    rd(5'h00);
    check(d, 16'h0000);
    foreach (rows[i]) begin
      @(posedge clk);
      spd <= rows[i].spd;
      wr(OPT, rows[i].wd);
      rd(OPT);
      check(d, rows[i].rb);
      check({10'h000, lpc, lpt, ser, sq, hb, ph}, {10'h000, rows[i].outs[4], rows[i].outs});
    end
    // Enable low: a write must not land
    @(posedge clk);
    ce <= 1'b0;
    wr(OPT, 16'h0004);
    @(posedge clk);
    ce <= 1'b1;
    rd(OPT);
    check(d, 16'h0000);
    wr(NP, 16'hFFFF);
    rd(NP);
    check(d, 16'hB7FF);
    @(posedge clk);
    rxack <= 1'b1;
    txack <= 1'b1;
    wr(NP, 16'hA123);
    rd(NP);
    check(d, 16'hE123);
    check({15'h0, pend}, 16'h0001);
    lm.exchange(1'b1, 1'b1);
    settle(2);
    check(txp, 16'hE123);
    lm.exchange(1'b0, 1'b0);
    settle(2);
    check(txp, 16'hE923);
    check({15'h0, pend}, 16'h0000);
    lm.exchange(1'b0, 1'b0);
    lm.exchange(1'b1, 1'b0);
    settle(2);
    rd(NP);
    check(d, 16'hE923);
    @(posedge clk);
    spd <= 1'b0;
    rxd <= 1'b1;
    wr(OPT, 16'h0008);
    // Interrupted run: agreeing pulse restarts the count
    lm.pulses(1'b1, 2);
    lm.pulses(1'b0, 1);
    lm.pulses(1'b1, 2);
    settle(2);
    check({14'h0, inv, rxo}, 16'h0001);
    lm.pulses(1'b1, 1);
    settle(3);
    check({13'h0, inv, st, rxo}, 16'h0006);
    lm.pulses(1'b0, 3);
    settle(2);
    check({14'h0, inv, st}, 16'h0000);
    wr(OPT, 16'h0000);
    lm.pulses(1'b1, 3);
    settle(3);
    check({13'h0, inv, st, rxo}, 16'h0004);
    @(posedge clk);
    spd <= 1'b1;
    settle(2);
    check({14'h0, inv, st}, 16'h0000);
    // Mid-run reset clears options and the toggle
    wr(OPT, 16'h003F);
    @(posedge clk);
    nrst <= 1'b0;
    settle(2);
    check(txp, 16'h0000);
    check({13'h0, lpt, ph, rv}, 16'h0000);
    @(posedge clk);
    nrst <= 1'b1;
    rd(OPT);
    check(d, ptonp_pkg::OPT_RESET);
    rd(NP);
    check(d, 16'h4000);
    end_sim();
  end
endmodule : ptonp_regs_tb
